// ---- common/ioe_map.vh ----
// Constants for the I/O instruction group executor.
`ifndef IOE_MAP_VH
`define IOE_MAP_VH
`define IOE_OP_HALT 3'h0
`define IOE_OP_FLAG 3'h1
`define IOE_OP_SKIP_CLR 3'h2
`define IOE_OP_SKIP_SET 3'h3
`define IOE_OP_MERGE 3'h4
`define IOE_OP_LOAD 3'h5
`define IOE_OP_OUTPUT 3'h6
`define IOE_OP_CONTROL 3'h7
`define IOE_SC_OVERFLOW 6'h01
`define IOE_SC_SYSTEM 6'h00
`define IOE_SC_FIRST_CARD 6'h06
`define IOE_BIT_ACC 11
`define IOE_BIT_HC 9
`define IOE_ST_IDLE 2'h0
`define IOE_ST_DATA 2'h1
`define IOE_ST_DONE 2'h2
`endif

// ---- src/ioe_executor.v ----
// I/O instruction group decoder and executor.
`timescale 1ns/10ps
`default_nettype none
`include "ioe_map.vh"
module ioe_executor #(
  parameter WIDTH = 16
) (
  input wire CLOCK,
  input wire RST_B,
  input wire EXEC_STROBE,
  input wire [15:0] INSTR,
  input wire [14:0] PC_IN,
  input wire [WIDTH-1:0] ACC_A_IN,
  input wire [WIDTH-1:0] ACC_B_IN,
  input wire OVERFLOW_IN,
  input wire MEM_PROTECT_ON,
  input wire GLOBAL_REG_ON,
  input wire [5:0] GLOBAL_SELECT,
  input wire CODE_DATA_SEPARATION_MODE,
  input wire BREAK_ENABLED_ANY,
  input wire IO_FLAG_IN,
  input wire [WIDTH-1:0] IO_DATA_IN,
  output reg DONE,
  output reg NOT_IO,
  output reg INHIBITED,
  output reg [14:0] PC_OUT,
  output reg ACC_A_WE,
  output reg ACC_B_WE,
  output reg [WIDTH-1:0] ACC_OUT,
  output reg OVERFLOW_WE,
  output reg OVERFLOW_OUT,
  output reg HALT,
  output reg [15:0] HOLD_WORD,
  output reg PANEL_START,
  output reg INT_SYSTEM_ON,
  output reg [5:0] IO_SELECT,
  output reg IO_GLOBAL,
  output reg IO_SET_CONTROL,
  output reg IO_CLEAR_CONTROL,
  output reg IO_CLEAR_ALL_CONTROL,
  output reg IO_SET_FLAG,
  output reg IO_CLEAR_FLAG,
  output reg IO_READ,
  output reg IO_WRITE,
  output reg [WIDTH-1:0] IO_DATA_OUT
);

  // ********************************************************
  // Decode
  // ********************************************************
  // group recognition
  wire is_io = INSTR[15] & (INSTR[14:12] == 3'h0) & INSTR[10];
  wire [2:0] op = INSTR[8:6];
  wire acc_b = INSTR[`IOE_BIT_ACC];
  wire [5:0] code = INSTR[5:0];
  wire [14:0] pc_next1 = PC_IN + 15'h0001;
  wire [WIDTH-1:0] acc_sel = acc_b ? ACC_B_IN : ACC_A_IN;

  reg [1:0] state;
  reg [15:0] instr_q;
  reg [14:0] pc_q;
  reg [WIDTH-1:0] acc_q;

  // ********************************************************
  // Fields of the word under execution
  // ********************************************************
  // The data cycle works from the captured word, so a new INSTR value
  // presented while the block is busy cannot disturb the operation.
  wire [2:0] op_q = instr_q[8:6];
  wire hc = instr_q[`IOE_BIT_HC];
  wire sense_q = instr_q[6];
  wire [5:0] code_q = instr_q[5:0];
  // Codes 00 and 01 mean the system and the overflow bit only with the global register off.
  wire system_code = (code_q == `IOE_SC_SYSTEM) & ~IO_GLOBAL;
  // The overflow skips share codes with flag skips; code 01 steers them to overflow.
  wire ovf_code = (code_q == `IOE_SC_OVERFLOW) & ~IO_GLOBAL;
  wire card_code = (code_q >= 6'h08) | IO_GLOBAL;
  wire [14:0] pc_next2 = pc_q + 15'h0002;

  // ********************************************************
  // Timing
  // ********************************************************
  // A word is taken at a rising edge with the strobe high and the sequencer idle.
  // In the next cycle the select code, the data out and the read or write request
  // are presented to the cards, and the next program counter is shown.
  // In the cycle after that the addressed card's flag and data are sampled, the
  // effect strobes pulse together with the done pulse, and a skip replaces the
  // program counter.
  // One more cycle passes before the next word can be taken.
  // A foreign word or an inhibited word is answered one cycle after the take.
  // Strobes that arrive while the sequencer is busy are dropped, not queued.
  // The cost of the extra cycle is small, and it gives the cards a full cycle
  // to decode the select code before their flag or data is sampled.

  // ********************************************************
  // Limits
  // ********************************************************
  // With the global register off, the hold or clear option is ignored on codes below 10 octal, except that code 01 skips clear overflow.
  // Set flag and clear flag never honour the option, since bit 9 chooses
  // between them.
  // The data read during a halt is not used.
  // The interrupt system bit is a plain level: the interrupt logic proper lives
  // outside this block.

  // ********************************************************
  // Execution sequencer
  // ********************************************************
  // Code and data separation mode is sampled nowhere: the group behaves the same in both.
  always @(posedge CLOCK)
  begin
    DONE <= 1'b0;
    NOT_IO <= 1'b0;
    INHIBITED <= 1'b0;
    ACC_A_WE <= 1'b0;
    ACC_B_WE <= 1'b0;
    OVERFLOW_WE <= 1'b0;
    PANEL_START <= 1'b0;
    IO_SET_CONTROL <= 1'b0;
    IO_CLEAR_CONTROL <= 1'b0;
    IO_CLEAR_ALL_CONTROL <= 1'b0;
    IO_SET_FLAG <= 1'b0;
    IO_CLEAR_FLAG <= 1'b0;
    IO_READ <= 1'b0;
    IO_WRITE <= 1'b0;
    if (!RST_B)
    begin
      state <= `IOE_ST_IDLE;
      instr_q <= 16'h0000;
      pc_q <= 15'h0000;
      acc_q <= {WIDTH{1'b0}};
      PC_OUT <= 15'h0000;
      ACC_OUT <= {WIDTH{1'b0}};
      OVERFLOW_OUT <= 1'b0;
      HALT <= 1'b0;
      HOLD_WORD <= 16'h0000;
      INT_SYSTEM_ON <= 1'b0;
      IO_SELECT <= 6'h00;
      IO_GLOBAL <= 1'b0;
      IO_DATA_OUT <= {WIDTH{1'b0}};
    end
    else
    begin
      case (state)
        `IOE_ST_IDLE:
        begin
          if (EXEC_STROBE)
          begin
            instr_q <= INSTR;
            pc_q <= PC_IN;
            acc_q <= acc_sel;
            PC_OUT <= pc_next1;
            IO_SELECT <= GLOBAL_REG_ON ? GLOBAL_SELECT : code;
            IO_GLOBAL <= GLOBAL_REG_ON;
            HALT <= 1'b0;
            if (!is_io)
            begin
              NOT_IO <= 1'b1;
              DONE <= 1'b1;
            end
            else if (MEM_PROTECT_ON)
            begin
              INHIBITED <= 1'b1;
              DONE <= 1'b1;
            end
            else
            begin
              state <= `IOE_ST_DATA;
              IO_READ <= (op == `IOE_OP_LOAD) | (op == `IOE_OP_MERGE) |
                         (op == `IOE_OP_SKIP_CLR) | (op == `IOE_OP_SKIP_SET) |
                         (op == `IOE_OP_HALT);
              IO_WRITE <= (op == `IOE_OP_OUTPUT);
              IO_DATA_OUT <= acc_sel;
            end
          end
        end
        `IOE_ST_DATA:
        begin
          state <= `IOE_ST_DONE;
          DONE <= 1'b1;
          case (op_q)
            `IOE_OP_CONTROL:
            begin
              if (!instr_q[`IOE_BIT_ACC])
                IO_SET_CONTROL <= 1'b1;
              else if (system_code)
                IO_CLEAR_ALL_CONTROL <= 1'b1;
              else
                IO_CLEAR_CONTROL <= 1'b1;
            end
            `IOE_OP_FLAG:
            begin
              // Bit 9 picks clear or set here; bit 11 plays no part in this operation.
              if (system_code)
                INT_SYSTEM_ON <= ~hc;
              else if (ovf_code)
              begin
                OVERFLOW_WE <= 1'b1;
                OVERFLOW_OUT <= ~hc;
              end
              else if (hc)
                IO_CLEAR_FLAG <= 1'b1;
              else
                IO_SET_FLAG <= 1'b1;
            end
            `IOE_OP_SKIP_CLR, `IOE_OP_SKIP_SET:
            begin
              if (ovf_code)
              begin
                if (sense_q == OVERFLOW_IN)
                  PC_OUT <= pc_next2;
                if (hc)
                begin
                  OVERFLOW_WE <= 1'b1;
                  OVERFLOW_OUT <= 1'b0;
                end
              end
              else if (IO_FLAG_IN == sense_q)
                PC_OUT <= pc_next2;
            end
            `IOE_OP_LOAD, `IOE_OP_MERGE:
            begin
              ACC_A_WE <= ~instr_q[`IOE_BIT_ACC];
              ACC_B_WE <= instr_q[`IOE_BIT_ACC];
              ACC_OUT <= (op_q == `IOE_OP_MERGE) ? (acc_q | IO_DATA_IN) : IO_DATA_IN;
            end
            `IOE_OP_HALT:
            begin
              if (BREAK_ENABLED_ANY)
              begin
                HALT <= 1'b1;
                PANEL_START <= 1'b1;
                HOLD_WORD <= instr_q;
              end
            end
            default:
            begin
            end
          endcase
          if (hc & card_code & (op_q != `IOE_OP_FLAG) &
              ((op_q != `IOE_OP_HALT) | BREAK_ENABLED_ANY))
            IO_CLEAR_FLAG <= 1'b1;
        end
        `IOE_ST_DONE:
        begin
          state <= `IOE_ST_IDLE;
        end
        default:
        begin
          state <= `IOE_ST_IDLE;
        end
      endcase
    end
  end

endmodule // ioe_executor
`default_nettype wire

// ---- bench/ioe_executor_properties.sv ----
// Port-level assertions for the I/O instruction executor.
`timescale 1ns/10ps
`default_nettype none
module ioe_executor_properties (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic DONE, NOT_IO, INHIBITED, ACC_A_WE, ACC_B_WE, HALT, PANEL_START,
  input wire logic INT_SYSTEM_ON, IO_CLEAR_ALL_CONTROL, IO_READ, IO_WRITE,
  input wire logic [14:0] PC_OUT,
  input wire logic [15:0] HOLD_WORD,
  input wire logic [5:0] IO_SELECT
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  // ********
  // Checks
  // ********
  sequence s_out_done;
    ##1 (DONE && !ACC_A_WE && !ACC_B_WE);
  endsequence
  sequence s_read_done;
    IO_READ ##1 DONE;
  endsequence
  chk_inhibit_quiet: assert property (INHIBITED |-> DONE && !ACC_A_WE && !HALT)
    else $error("inhibited word took effect");
  chk_notio_quiet: assert property (NOT_IO |-> DONE && !IO_READ && !IO_WRITE)
    else $error("foreign word reached the cards");
  chk_output_keeps: assert property (IO_WRITE |-> s_out_done)
    else $error("output changed an accumulator");
  chk_read_step: assert property (s_read_done |-> PC_OUT - $past(PC_OUT) <= 15'h0001)
    else $error("bad program counter step");
  chk_acc_select: assert property ((ACC_A_WE || ACC_B_WE) |-> DONE && !(ACC_A_WE && ACC_B_WE))
    else $error("both accumulators written");
  chk_clear_all: assert property (IO_CLEAR_ALL_CONTROL |-> DONE && IO_SELECT == 6'h00)
    else $error("clear all without code zero");
  chk_int_enable: assert property ($rose(INT_SYSTEM_ON) |-> IO_SELECT == 6'h00)
    else $error("interrupt system enabled by card code");
  chk_halt_panel: assert property (PANEL_START |-> DONE && HALT && HOLD_WORD[8:6] == 3'h0)
    else $error("panel start without halt");
endmodule // ioe_executor_properties
bind ioe_executor ioe_executor_properties chk (
  .CLOCK(CLOCK), .RST_B(RST_B), .DONE(DONE), .NOT_IO(NOT_IO), .INHIBITED(INHIBITED),
  .ACC_A_WE(ACC_A_WE), .ACC_B_WE(ACC_B_WE), .HALT(HALT), .PANEL_START(PANEL_START),
  .INT_SYSTEM_ON(INT_SYSTEM_ON), .IO_CLEAR_ALL_CONTROL(IO_CLEAR_ALL_CONTROL),
  .IO_READ(IO_READ), .IO_WRITE(IO_WRITE), .PC_OUT(PC_OUT), .HOLD_WORD(HOLD_WORD),
  .IO_SELECT(IO_SELECT)
);
`default_nettype wire

// ---- bench/ioe_card.sv ----
// Behavioural model of one I/O card.
`timescale 1ns/10ps
`default_nettype none
module ioe_card #(
  parameter [5:0] CODE = 6'h0A
) (
  input wire logic clock, rst_b, io_global, set_flag, clear_flag, write,
  input wire logic [5:0] select, global_select,
  input wire logic [15:0] data_in,
  output logic flag_out,
  output logic [15:0] data_out
);
  logic flag;
  logic [15:0] buffer;
  logic mine;
  assign mine = (io_global ? global_select : select) == CODE;
  always @(posedge clock)
    if (!rst_b)
    begin
      flag <= 1'b0;
      buffer <= 16'h0000;
    end
    else if (mine)
    begin
      if (set_flag) flag <= 1'b1;
      if (clear_flag) flag <= 1'b0;
      if (write) buffer <= data_in;
    end
  // Unselected, the lines show inverted values so that a stale read cannot pass.
  assign flag_out = mine ? flag : ~flag;
  assign data_out = mine ? buffer : ~buffer;
endmodule // ioe_card
`default_nettype wire

// ---- bench/ioe_executor_tb.sv ----
// Self-checking bench for the I/O instruction executor.
`timescale 1ns/10ps
`default_nettype none
module ioe_executor_tb;
  logic CLOCK = 1'b0, RST_B = 1'b0, EXEC_STROBE = 1'b0, OVERFLOW_IN = 1'b0;
  logic MEM_PROTECT_ON = 1'b0, GLOBAL_REG_ON = 1'b0, CODE_DATA_SEPARATION_MODE = 1'b0;
  logic BREAK_ENABLED_ANY = 1'b1, IO_FLAG_IN, DONE, NOT_IO, INHIBITED, ACC_A_WE, ACC_B_WE;
  logic OVERFLOW_WE, OVERFLOW_OUT, HALT, PANEL_START, INT_SYSTEM_ON, IO_GLOBAL, IO_READ;
  logic IO_SET_CONTROL, IO_CLEAR_CONTROL, IO_CLEAR_ALL_CONTROL, IO_SET_FLAG, IO_CLEAR_FLAG;
  logic IO_WRITE;
  logic [15:0] INSTR = 16'h0000, ACC_A_IN = 16'h0000, ACC_B_IN = 16'h0000;
  logic [15:0] IO_DATA_IN, ACC_OUT, HOLD_WORD, IO_DATA_OUT;
  logic [14:0] PC_IN = 15'h0100, PC_OUT;
  logic [5:0] GLOBAL_SELECT = 6'h0A, IO_SELECT;
  logic [63:0] r;
  int i, miscompares = 0, n_compared = 0;
  // ********
  // Cases: word, accumulator A, expected data, expected strobes
  // ********
  logic [63:0] rows [20] = '{64'h858A_1234_0000_0000, 64'h8D8A_0F0F_0000_0000,
    64'h854A_0000_F0F0_4000, 64'h8D0A_FF00_F0FF_2000, 64'h844A_0000_0000_0020,
    64'h84CA_0000_0000_1000, 64'h848A_0000_0000_0000, 64'h874A_0000_F0F0_4010,
    64'h848A_0000_0000_1000, 64'h864A_0000_0000_0010, 64'h85CA_0000_0000_0100,
    64'h8DCA_0000_0000_0080, 64'h8DC0_0000_0000_0040, 64'h86C1_0000_0000_9800,
    64'h8481_0000_0000_8000, 64'h8681_0000_0000_1800, 64'h8641_0000_0000_0800,
    64'h8C41_0000_0000_0C00, 64'h8440_0000_0000_0200, 64'h8640_0000_0000_0000};
  ioe_executor uut (.*);
  ioe_card card (.clock(CLOCK), .rst_b(RST_B), .io_global(IO_GLOBAL), .set_flag(IO_SET_FLAG),
    .clear_flag(IO_CLEAR_FLAG), .write(IO_WRITE), .select(IO_SELECT),
    .global_select(GLOBAL_SELECT), .data_in(IO_DATA_OUT), .flag_out(IO_FLAG_IN),
    .data_out(IO_DATA_IN));
  always #25 CLOCK = ~CLOCK;
  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check_value(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // B gets the inverse of A so that a wrong accumulator choice shows.
  task automatic exec(input logic [15:0] word, a, input logic ovf, code_data_separation_mode);
    int n;
    @(posedge CLOCK);
    {INSTR, ACC_A_IN, ACC_B_IN} <= {word, a, ~a};
    {OVERFLOW_IN, CODE_DATA_SEPARATION_MODE, EXEC_STROBE} <= {ovf, code_data_separation_mode, 1'b1};
    @(posedge CLOCK);
    EXEC_STROBE <= 1'b0;
    #1;
    for (n = 0; n < 4 && DONE !== 1'b1; n++)
      @(posedge CLOCK) #1;
    if (DONE !== 1'b1)
    begin
      miscompares++;
      complete_run();
    end
  endtask
  initial
  begin
    repeat (16) @(posedge CLOCK);
    RST_B <= 1'b1;
    #1 check_value({DONE, HALT, HOLD_WORD, ACC_OUT}, 48'h0);
    for (i = 0; i < 20; i++)
    begin
      r = rows[i];
      exec(r[63:48], r[47:32], r[15], i[0]);
      check_value({r[15], ACC_A_WE, ACC_B_WE, r[12], OVERFLOW_WE, OVERFLOW_OUT & OVERFLOW_WE,
        INT_SYSTEM_ON, IO_SET_CONTROL, IO_CLEAR_CONTROL, IO_CLEAR_ALL_CONTROL, IO_SET_FLAG,
        IO_CLEAR_FLAG, 4'h0}, r[15:0]);
      check_value(PC_OUT, PC_IN + 15'h0001 + r[12]);
      if (r[14:13] != 2'b00)
        check_value(ACC_OUT, r[31:16]);
    end
    @(posedge CLOCK) GLOBAL_REG_ON <= 1'b1;
    exec(16'h8543, 16'h0000, 1'b0, 1'b0);
    check_value({IO_GLOBAL, ACC_OUT}, {1'b1, 16'hF0F0});
    @(posedge CLOCK) {GLOBAL_REG_ON, MEM_PROTECT_ON} <= 2'b01;
    exec(16'h854A, 16'h0000, 1'b0, 1'b0);
    check_value({INHIBITED, DONE, ACC_A_WE}, 3'b110);
    @(posedge CLOCK) {MEM_PROTECT_ON, BREAK_ENABLED_ANY} <= 2'b00;
    exec(16'h0000, 16'h0000, 1'b0, 1'b0);
    check_value({NOT_IO, DONE}, 2'b11);
    exec(16'h840A, 16'h0000, 1'b0, 1'b0);
    check_value({HALT, PANEL_START}, 2'b00);
    @(posedge CLOCK) BREAK_ENABLED_ANY <= 1'b1;
    exec(16'h860A, 16'h0000, 1'b0, 1'b0);
    check_value({HALT, PANEL_START, IO_CLEAR_FLAG, HOLD_WORD, PC_OUT},
      {3'h7, 16'h860A, 15'h0101});
    @(posedge CLOCK) RST_B <= 1'b0;
    @(posedge CLOCK) RST_B <= 1'b1;
    #1 check_value({HALT, HOLD_WORD}, 48'h0);
    complete_run();
  end
endmodule // ioe_executor_tb
`default_nettype wire
